/* File: hdl/fbx_pkg.sv */
package fbx_pkg;
// Functional notes
// RULE1: taken branch runs in exec stage 1; target enters stage 1 after five slots
// RULE2: while branch sits in exec stage 1, target packet is in address generate phase
// RULE3: branches run on shift unit b and read second source port in stage 1
// RULE4: two-cycle doubles read low half on first port, high half on second, stage 1
// RULE5: two-cycle doubles write low half stage 1, high half stage 2, on shift units
// RULE6: two-cycle doubles update aux status in stage 1
// RULE7: four-cycle ops read in stage 1, write in stage 4, three delay slots
// RULE8: four-cycle ops on multiply or logic units; status update in stage 4
// RULE9: int-to-double reads second port stage 1, writes low stage 4, high stage 5
// RULE10: int-to-double updates add/convert status in stage 4
// RULE11: double compares read low halves stage 1, high stage 2, write stage 2
// RULE12: double compares hold their shift unit for two cycles
// RULE13: double compares update aux status in stage 2
// RULE14: double add/subtract read low stage 1, high stage 2, write stages 6 and 7
// RULE15: double add/subtract latency two; add/convert status updated in stage 6
// RULE16: 32-bit integer multiply reads stages 1 to 4, writes stage 9
// RULE17: 32-bit integer multiply holds its multiply unit four cycles
// RULE18: wide multiply reads stages 1 to 4, writes low stage 9, high stage 10
// RULE19: double multiply reads source halves in the fixed four-stage pattern
// RULE20: double multiply writes stages 9 and 10, multiply status in stage 9
// RULE21: double multiply runs on multiply units with latency four
// RULE22: refuse issue to a unit still inside its latency window
// RULE23: each result half commits independently at its own stage

  localparam int FBX_SIDES = 2;
  localparam int FBX_KINDS = 3;
  localparam int FBX_UNITS = 6;
  localparam int FBX_STAGES = 10;
  localparam int FBX_TAG_W = 5;
  localparam int FBX_BR_UNIT = 4;
  localparam logic [2:0] FBX_BR_SLOTS = 3'h5;

  localparam logic [3:0] ST_E1 = 4'h1;
  localparam logic [3:0] ST_E2 = 4'h2;
  localparam logic [3:0] ST_E3 = 4'h3;
  localparam logic [3:0] ST_E4 = 4'h4;
  localparam logic [3:0] ST_E5 = 4'h5;
  localparam logic [3:0] ST_E6 = 4'h6;
  localparam logic [3:0] ST_E7 = 4'h7;
  localparam logic [3:0] ST_E9 = 4'h9;
  localparam logic [3:0] ST_E10 = 4'ha;

  localparam logic [2:0] LAT_ONE = 3'h1;
  localparam logic [2:0] LAT_CMP = 3'h2;
  localparam logic [2:0] LAT_DPADD = 3'h2;
  localparam logic [2:0] LAT_MPY = 3'h4;

  typedef enum logic [1:0] {UK_L = 2'h0, UK_S = 2'h1, UK_M = 2'h2} fbx_kind_t;

  typedef enum logic [3:0] {
    CL_BRANCH = 4'h0, CL_DP2 = 4'h1, CL_FOUR = 4'h2, CL_INT_TO_DOUBLE_CONVERT = 4'h3, CL_DPCMP = 4'h4,
    CL_DPADD = 4'h5, CL_INT_MULTIPLY_32 = 4'h6, CL_INT_MULTIPLY_WIDE = 4'h7, CL_DOUBLE_MULTIPLY = 4'h8
  } fbx_cls_t;

  typedef enum logic [7:0] {
    BP_IDLE = 8'h01, BP_PG = 8'h02, BP_PS = 8'h04, BP_PW = 8'h08,
    BP_PR = 8'h10, BP_DP = 8'h20, BP_DC = 8'h40, BP_E1 = 8'h80
  } fbx_bphase_t;

  // unit numbering: side * 3 + kind
  function automatic fbx_kind_t fbx_unit_kind(input int u);
    return fbx_kind_t'(2'(u % FBX_KINDS));
  endfunction

  // which unit kinds may run each class
  function automatic logic fbx_legal(input fbx_cls_t c, input fbx_kind_t k, input logic side);
    logic ok;
    ok = 1'b0;
    case (c)
      CL_BRANCH: ok = (k == UK_S) && side; // RULE3
      CL_DP2, CL_DPCMP: ok = (k == UK_S);
      CL_FOUR: ok = (k == UK_M) || (k == UK_L); // RULE8
      CL_INT_TO_DOUBLE_CONVERT, CL_DPADD: ok = (k == UK_L);
      CL_INT_MULTIPLY_32, CL_INT_MULTIPLY_WIDE, CL_DOUBLE_MULTIPLY: ok = (k == UK_M); // RULE21
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // functional-unit occupancy in cycles
  function automatic logic [2:0] fbx_latency(input fbx_cls_t c);
    logic [2:0] l;
    l = LAT_ONE;
    case (c)
      CL_DPCMP: l = LAT_CMP; // RULE12
      CL_DPADD: l = LAT_DPADD; // RULE15
      CL_INT_MULTIPLY_32, CL_INT_MULTIPLY_WIDE, CL_DOUBLE_MULTIPLY: l = LAT_MPY; // RULE17
      default: l = LAT_ONE;
    endcase
    return l;
  endfunction
endpackage

/* File: hdl/fbx_if.sv */
// issue handshake between the timing core and one unit gate
interface fbx_gate_if;
  import fbx_pkg::*;
  logic req;
  fbx_cls_t cls;
  logic take;
  logic ready;
  logic refused;
  logic busy;
  modport gate (input req, input cls, output take, output ready, output refused, output busy);
  modport core (output req, output cls, input take, input ready, input refused, input busy);
endinterface

// branch start and fetch phase tracking
interface fbx_branch_if;
  import fbx_pkg::*;
  logic start;
  fbx_bphase_t phase;
  logic [2:0] slot;
  logic fetchGen;
  logic targetE1;
  modport ctl (input start, output phase, output slot, output fetchGen, output targetE1);
  modport core (output start, input phase, input slot, input fetchGen, input targetE1);
endinterface

/* File: hdl/fbx_unit_gate.sv */
module fbx_unit_gate
  import fbx_pkg::*;
#(
  parameter fbx_kind_t KIND = UK_L,
  parameter logic SIDE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  fbx_gate_if.gate gif
);
  typedef struct packed {
    logic [2:0] cnt;
    logic ready;
    logic refused;
    logic busy;
  } fbx_gate_st_t;

  fbx_gate_st_t s_q;
  fbx_gate_st_t s_d;
  logic legal;
  logic take;

  // accept only when idle and the class belongs on this unit
  always_comb begin
    s_d = s_q;
    legal = fbx_legal(gif.cls, KIND, SIDE);
    take = gif.req && s_q.ready && legal; // RULE22
    if (take) begin
      s_d.cnt = fbx_latency(gif.cls) - 3'h1;
    end else if (s_q.cnt != 3'h0) begin
      s_d.cnt = s_q.cnt - 3'h1;
    end
    s_d.ready = (s_d.cnt == 3'h0);
    s_d.busy = (s_d.cnt != 3'h0);
    s_d.refused = gif.req && !take;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign gif.take = take;
  assign gif.ready = s_q.ready;
  assign gif.refused = s_q.refused;
  assign gif.busy = s_q.busy;
endmodule

/* File: hdl/fbx_branch_ctl.sv */
module fbx_branch_ctl
  import fbx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  fbx_branch_if.ctl bif
);
  typedef struct packed {
    fbx_bphase_t phase;
    logic [2:0] slot;
    logic fetchGen;
    logic targetE1;
  } fbx_br_st_t;

  fbx_br_st_t s_q;
  fbx_br_st_t s_d;

  // target packet walks the fetch phases; a new branch restarts it
  always_comb begin
    s_d = s_q;
    if (bif.start) begin
      s_d.phase = BP_PG; // RULE2
      s_d.slot = 3'h0;
    end else begin
      unique case (s_q.phase)
        BP_IDLE: s_d.phase = BP_IDLE;
        BP_PG: s_d.phase = BP_PS;
        BP_PS: s_d.phase = BP_PW;
        BP_PW: s_d.phase = BP_PR;
        BP_PR: s_d.phase = BP_DP;
        BP_DP: s_d.phase = BP_DC;
        BP_DC: s_d.phase = BP_E1;
        BP_E1: s_d.phase = BP_IDLE;
        default: s_d.phase = BP_IDLE;
      endcase
      if (s_d.phase == BP_E1 || s_d.phase == BP_IDLE) begin
        s_d.slot = 3'h0;
      end else if (s_q.slot < FBX_BR_SLOTS) begin
        s_d.slot = s_q.slot + 3'h1; // RULE1
      end
    end
    // phase flags are kept in flops so the top outputs carry no decode
    s_d.fetchGen = (s_d.phase == BP_PG); // RULE2
    s_d.targetE1 = (s_d.phase == BP_E1); // RULE1
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '{phase: BP_IDLE, slot: 3'h0, fetchGen: 1'b0, targetE1: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bif.phase = s_q.phase;
  assign bif.slot = s_q.slot;
  assign bif.fetchGen = s_q.fetchGen;
  assign bif.targetE1 = s_q.targetE1; // RULE1
endmodule

/* File: hdl/fbx_exec_timing.sv */
module fbx_exec_timing
  import fbx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [FBX_UNITS-1:0] issueValid,
  input wire fbx_cls_t [FBX_UNITS-1:0] issueCls,
  input wire logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] issueTag,
  output logic [FBX_UNITS-1:0] unitReady,
  output logic [FBX_UNITS-1:0] issueRefused,
  output logic [FBX_UNITS-1:0] unitBusy,
  output logic [FBX_UNITS-1:0] readFirstLo,
  output logic [FBX_UNITS-1:0] readFirstHi,
  output logic [FBX_UNITS-1:0] readSecondLo,
  output logic [FBX_UNITS-1:0] readSecondHi,
  output logic [FBX_UNITS-1:0] writeLo,
  output logic [FBX_UNITS-1:0] writeHi,
  output logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] writeTagLo,
  output logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] writeTagHi,
  output logic auxStatusUpd,
  output logic mulStatusUpd,
  output logic addStatusUpd,
  output logic [FBX_UNITS-1:0] unitStatusUpd,
  output logic branchExec,
  output logic branchFetchGen,
  output fbx_bphase_t branchPhase,
  output logic [2:0] branchSlot,
  output logic branchTargetExec
);
  // per-stage control strobes of one unit
  typedef struct packed {
    logic rdFirstLo;
    logic rdFirstHi;
    logic rdSecondLo;
    logic rdSecondHi;
    logic wrLo;
    logic wrHi;
    logic stAux;
    logic stMul;
    logic stAdd;
    logic brE1;
  } fbx_ctl_t;

  // one instruction in flight at one execute stage
  typedef struct packed {
    logic vld;
    fbx_cls_t cls;
    logic [FBX_TAG_W-1:0] tag;
  } fbx_rec_t;

  typedef struct packed {
    fbx_rec_t [FBX_UNITS-1:0][FBX_STAGES-1:0] rec;
    fbx_ctl_t [FBX_UNITS-1:0] ctl;
    logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] tagLo;
    logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] tagHi;
    logic aux;
    logic mul;
    logic add;
    logic [FBX_UNITS-1:0] ust;
  } fbx_st_t;

  fbx_st_t s_q;
  fbx_st_t s_d;
  logic [FBX_UNITS-1:0] take;

  fbx_gate_if gif[FBX_UNITS] ();
  fbx_branch_if bif ();

  // strobes owed by class c on unit kind k at execute stage st
  function automatic fbx_ctl_t fbx_decode(input fbx_cls_t c, input fbx_kind_t k, input logic [3:0] st);
    fbx_ctl_t r;
    r = '0;
    case (c)
      CL_BRANCH: begin
        if (st == ST_E1) begin
          r.rdSecondLo = 1'b1; // RULE3
          r.brE1 = 1'b1; // RULE1
        end
      end
      CL_DP2: begin
        if (st == ST_E1) begin
          r.rdFirstLo = 1'b1; // RULE4
          r.rdSecondHi = 1'b1; // RULE4
          r.wrLo = 1'b1; // RULE5
          r.stAux = 1'b1; // RULE6
        end
        if (st == ST_E2) begin
          r.wrHi = 1'b1; // RULE5
        end
      end
      CL_FOUR: begin
        if (st == ST_E1) begin
          r.rdFirstLo = 1'b1; // RULE7
          r.rdSecondLo = 1'b1;
        end
        if (st == ST_E4) begin
          r.wrLo = 1'b1; // RULE7
          r.stMul = (k == UK_M); // RULE8
          r.stAdd = (k == UK_L); // RULE8
        end
      end
      CL_INT_TO_DOUBLE_CONVERT: begin
        if (st == ST_E1) begin
          r.rdSecondLo = 1'b1; // RULE9
        end
        if (st == ST_E4) begin
          r.wrLo = 1'b1; // RULE9
          r.stAdd = 1'b1; // RULE10
        end
        if (st == ST_E5) begin
          r.wrHi = 1'b1; // RULE9
        end
      end
      CL_DPCMP: begin
        if (st == ST_E1) begin
          r.rdFirstLo = 1'b1; // RULE11
          r.rdSecondLo = 1'b1;
        end
        if (st == ST_E2) begin
          r.rdFirstHi = 1'b1; // RULE11
          r.rdSecondHi = 1'b1;
          r.wrLo = 1'b1; // RULE11
          r.stAux = 1'b1; // RULE13
        end
      end
      CL_DPADD: begin
        if (st == ST_E1) begin
          r.rdFirstLo = 1'b1; // RULE14
          r.rdSecondLo = 1'b1;
        end
        if (st == ST_E2) begin
          r.rdFirstHi = 1'b1; // RULE14
          r.rdSecondHi = 1'b1;
        end
        if (st == ST_E6) begin
          r.wrLo = 1'b1; // RULE14
          r.stAdd = 1'b1; // RULE15
        end
        if (st == ST_E7) begin
          r.wrHi = 1'b1; // RULE14
        end
      end
      CL_INT_MULTIPLY_32, CL_INT_MULTIPLY_WIDE: begin
        if (st <= ST_E4) begin
          r.rdFirstLo = 1'b1; // RULE16
          r.rdSecondLo = 1'b1; // RULE18
        end
        if (st == ST_E9) begin
          r.wrLo = 1'b1; // RULE16
        end
        if (st == ST_E10 && c == CL_INT_MULTIPLY_WIDE) begin
          r.wrHi = 1'b1; // RULE18
        end
      end
      CL_DOUBLE_MULTIPLY: begin
        // first source: lo, lo, hi, hi; second source: lo, hi, lo, hi
        r.rdFirstLo = (st == ST_E1) || (st == ST_E2); // RULE19
        r.rdFirstHi = (st == ST_E3) || (st == ST_E4); // RULE19
        r.rdSecondLo = (st == ST_E1) || (st == ST_E3); // RULE19
        r.rdSecondHi = (st == ST_E2) || (st == ST_E4); // RULE19
        if (st == ST_E9) begin
          r.wrLo = 1'b1; // RULE20
          r.stMul = 1'b1; // RULE20
        end
        if (st == ST_E10) begin
          r.wrHi = 1'b1; // RULE20
        end
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // one gate per unit holds its occupancy window
  for (genvar u = 0; u < FBX_UNITS; u++) begin : g_unit
    assign gif[u].req = issueValid[u];
    assign gif[u].cls = issueCls[u];
    fbx_unit_gate #(
      .KIND(fbx_unit_kind(u)),
      .SIDE(1'(u / FBX_KINDS))
    ) u_gate (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .gif(gif[u])
    );
    assign take[u] = gif[u].take;
    assign unitReady[u] = gif[u].ready;
    assign issueRefused[u] = gif[u].refused;
    assign unitBusy[u] = gif[u].busy;
  end

  // a taken branch on shift unit b starts the target fetch
  assign bif.start = take[FBX_BR_UNIT] && (issueCls[FBX_BR_UNIT] == CL_BRANCH); // RULE2

  fbx_branch_ctl u_branch (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bif(bif)
  );

  // advance every in-flight instruction one stage and decode next strobes
  always_comb begin
    fbx_ctl_t c;
    c = '0;
    s_d = s_q;
    for (int u = 0; u < FBX_UNITS; u++) begin
      for (int st = FBX_STAGES - 1; st > 0; st--) begin
        s_d.rec[u][st] = s_q.rec[u][st-1];
      end
      if (take[u]) begin
        s_d.rec[u][0] = '{vld: 1'b1, cls: issueCls[u], tag: issueTag[u]};
      end else begin
        s_d.rec[u][0] = '0;
      end
    end
    s_d.aux = 1'b0;
    s_d.mul = 1'b0;
    s_d.add = 1'b0;
    for (int u = 0; u < FBX_UNITS; u++) begin
      s_d.ctl[u] = '0;
      s_d.tagLo[u] = '0;
      s_d.tagHi[u] = '0;
      // ascending walk: the oldest writer owns a shared half
      for (int st = 0; st < FBX_STAGES; st++) begin
        if (s_d.rec[u][st].vld) begin
          c = fbx_decode(s_d.rec[u][st].cls, fbx_unit_kind(u), 4'(st + 1));
          s_d.ctl[u] = s_d.ctl[u] | c;
          if (c.wrLo) begin
            s_d.tagLo[u] = s_d.rec[u][st].tag; // RULE23
          end
          if (c.wrHi) begin
            s_d.tagHi[u] = s_d.rec[u][st].tag; // RULE23
          end
        end
      end
      s_d.aux = s_d.aux | s_d.ctl[u].stAux;
      s_d.mul = s_d.mul | s_d.ctl[u].stMul;
      s_d.add = s_d.add | s_d.ctl[u].stAdd;
      s_d.ust[u] = s_d.ctl[u].stAux | s_d.ctl[u].stMul | s_d.ctl[u].stAdd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // registered strobes out to register file and status logic
  always_comb begin
    for (int u = 0; u < FBX_UNITS; u++) begin
      readFirstLo[u] = s_q.ctl[u].rdFirstLo;
      readFirstHi[u] = s_q.ctl[u].rdFirstHi;
      readSecondLo[u] = s_q.ctl[u].rdSecondLo;
      readSecondHi[u] = s_q.ctl[u].rdSecondHi;
      writeLo[u] = s_q.ctl[u].wrLo; // RULE23
      writeHi[u] = s_q.ctl[u].wrHi; // RULE23
    end
  end

  assign writeTagLo = s_q.tagLo;
  assign writeTagHi = s_q.tagHi;
  assign auxStatusUpd = s_q.aux;
  assign mulStatusUpd = s_q.mul;
  assign addStatusUpd = s_q.add;
  assign unitStatusUpd = s_q.ust;
  assign branchExec = s_q.ctl[FBX_BR_UNIT].brE1;
  assign branchFetchGen = bif.fetchGen;
  assign branchPhase = bif.phase;
  assign branchSlot = bif.slot;
  assign branchTargetExec = bif.targetE1;
endmodule

/* File: tb/fbx_exec_timing_sva.sv */
module fbx_exec_timing_sva
  import fbx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [FBX_UNITS-1:0] issueValid,
  input wire fbx_cls_t [FBX_UNITS-1:0] issueCls,
  input wire logic [FBX_UNITS-1:0] unitReady,
  input wire logic [FBX_UNITS-1:0] issueRefused,
  input wire logic [FBX_UNITS-1:0] unitBusy,
  input wire logic [FBX_UNITS-1:0] readFirstLo,
  input wire logic [FBX_UNITS-1:0] readFirstHi,
  input wire logic [FBX_UNITS-1:0] readSecondLo,
  input wire logic [FBX_UNITS-1:0] readSecondHi,
  input wire logic [FBX_UNITS-1:0] writeLo,
  input wire logic [FBX_UNITS-1:0] writeHi,
  input wire logic auxStatusUpd,
  input wire logic mulStatusUpd,
  input wire logic addStatusUpd,
  input wire logic branchExec,
  input wire logic branchFetchGen,
  input wire logic branchTargetExec
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // accepted issues of the classes watched here
  wire logic [FBX_UNITS-1:0] acc = issueValid & unitReady;
  wire logic mdp2 = acc[2] && issueCls[2] == CL_DOUBLE_MULTIPLY;
  wire logic mpy2 = acc[2] && issueCls[2] inside {CL_INT_MULTIPLY_32, CL_INT_MULTIPLY_WIDE, CL_DOUBLE_MULTIPLY};
  wire logic br4 = acc[4] && issueCls[4] == CL_BRANCH;
  wire logic four0 = acc[0] && issueCls[0] == CL_FOUR;
  wire logic idp0 = acc[0] && issueCls[0] == CL_INT_TO_DOUBLE_CONVERT;
  wire logic add0 = acc[0] && issueCls[0] == CL_DPADD;
  wire logic cmp1 = acc[1] && issueCls[1] == CL_DPCMP;
  wire logic dp21 = acc[1] && issueCls[1] == CL_DP2;

  // source half pattern of the double multiply over four stages
  sequence seqDpRead;
    readFirstLo[2] && readSecondLo[2] ##1 readFirstLo[2] && readSecondHi[2]
    ##1 readFirstHi[2] && readSecondLo[2] ##1 readFirstHi[2] && readSecondHi[2];
  endsequence
  // branch in stage 1 with target fetch starting, target in stage 1 six cycles on
  sequence seqBranch;
    branchExec && branchFetchGen && readSecondLo[4] ##6 branchTargetExec;
  endsequence

  dpmul_reads_a: assert property (mdp2 |=> seqDpRead)
    else $error("double multiply read order wrong");
  dpmul_write_a: assert property (mdp2 |-> ##9 writeLo[2] && mulStatusUpd ##1 writeHi[2])
    else $error("double multiply write stages wrong");
  mpy_window_a: assert property (mpy2 |=> unitBusy[2][*3] ##1 unitReady[2])
    else $error("multiply unit window wrong");
  branch_slots_a: assert property (br4 |=> seqBranch)
    else $error("branch delay slots wrong");
  issue_refuse_a: assert property (issueValid[2] && !unitReady[2] |=> issueRefused[2])
    else $error("busy unit took an issue");
  four_write_a: assert property (four0 |-> ##4 writeLo[0] && addStatusUpd)
    else $error("four cycle write stage wrong");
  int_to_double_convert_write_a: assert property (idp0 |-> ##4 writeLo[0] && addStatusUpd ##1 writeHi[0])
    else $error("int to double write stages wrong");
  cmp_stages_a: assert property (cmp1 |=> readFirstLo[1] && unitBusy[1]
    ##1 readFirstHi[1] && readSecondHi[1] && writeLo[1] && auxStatusUpd)
    else $error("double compare stages wrong");
  dpadd_write_a: assert property (add0 |-> ##6 writeLo[0] && addStatusUpd ##1 writeHi[0])
    else $error("double add write stages wrong");
  dp2_write_a: assert property (dp21 |=> writeLo[1] && auxStatusUpd ##1 writeHi[1])
    else $error("two cycle double write wrong");
endmodule

/* File: tb/test_fbx_exec_timing.sv */
module test_fbx_exec_timing
  import fbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [FBX_UNITS-1:0] iv = '0;
  fbx_cls_t [FBX_UNITS-1:0] ic;
  logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] it = '0;
  logic [FBX_UNITS-1:0] unitReady, issueRefused, unitBusy, readFirstLo, readFirstHi, readSecondLo, readSecondHi;
  logic [FBX_UNITS-1:0] writeLo, writeHi, unitStatusUpd;
  logic [FBX_UNITS-1:0][FBX_TAG_W-1:0] writeTagLo, writeTagHi;
  logic auxStatusUpd, mulStatusUpd, addStatusUpd, branchExec, branchFetchGen, branchTargetExec;
  fbx_bphase_t branchPhase;
  logic [2:0] branchSlot;
  int nFail = 0;
  int checked = 0;
  int cyc = 0;
  int tu[10] = '{4, 1, 0, 5, 0, 1, 0, 2, 5, 2};
  fbx_cls_t tc[10] = '{CL_BRANCH, CL_DP2, CL_FOUR, CL_FOUR, CL_INT_TO_DOUBLE_CONVERT, CL_DPCMP, CL_DPADD, CL_INT_MULTIPLY_32, CL_INT_MULTIPLY_WIDE, CL_DOUBLE_MULTIPLY};

  fbx_exec_timing i_fbx_exec_timing (
    .clk_sys, .nrst, .issueValid(iv), .issueCls(ic), .issueTag(it), .unitReady, .issueRefused, .unitBusy,
    .readFirstLo, .readFirstHi, .readSecondLo, .readSecondHi, .writeLo, .writeHi, .writeTagLo, .writeTagHi,
    .auxStatusUpd, .mulStatusUpd, .addStatusUpd, .unitStatusUpd, .branchExec, .branchFetchGen,
    .branchPhase, .branchSlot, .branchTargetExec
  );

  always #50 clk_sys = ~clk_sys;

  task automatic report_and_stop;
    $display("checked=%0d failed=%0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nFail++;
      report_and_stop;
    end
  end

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // {busy, aux, mul, add, rdFirstLo, rdFirstHi, rdSecondLo, rdSecondHi, wrLo, wrHi} per stage
  function automatic logic [15:0] want(input int u, input fbx_cls_t c, input int k);
    logic [9:0] w;
    w = 10'h0;
    case (c)
      CL_BRANCH: w = (k == 1) ? 10'h008 : 10'h0;
      CL_DP2: w = (k == 1) ? 10'h126 : (k == 2) ? 10'h001 : 10'h0;
      CL_FOUR: w = (k == 1) ? 10'h028 : (k == 4) ? ((u % 3 == 2) ? 10'h082 : 10'h042) : 10'h0;
      CL_INT_TO_DOUBLE_CONVERT: w = (k == 1) ? 10'h008 : (k == 4) ? 10'h042 : (k == 5) ? 10'h001 : 10'h0;
      CL_DPCMP: w = (k == 1) ? 10'h228 : (k == 2) ? 10'h116 : 10'h0;
      CL_DPADD: w = (k == 1) ? 10'h228 : (k == 2) ? 10'h014 : (k == 6) ? 10'h042 : (k == 7) ? 10'h001 : 10'h0;
      CL_DOUBLE_MULTIPLY: w = (k == 1) ? 10'h228 : (k == 2) ? 10'h224 : (k == 3) ? 10'h218 : (k == 4) ? 10'h014
        : (k == 9) ? 10'h082 : (k == 10) ? 10'h001 : 10'h0;
      default: w = (k < 4) ? 10'h228 : (k == 4) ? 10'h028 : (k == 9) ? 10'h002
        : (k == 10 && c == CL_INT_MULTIPLY_WIDE) ? 10'h001 : 10'h0;
    endcase
    return {5'h0, |w[8:6], w};
  endfunction

  // {exec, fetchGen, targetExec, slot, phase} for a lone branch
  function automatic logic [15:0] bw(input int k);
    fbx_bphase_t p[6] = '{BP_PG, BP_PS, BP_PW, BP_PR, BP_DP, BP_DC};
    if (k == 1) return {5'h06, 3'h0, BP_PG};
    if (k <= 6) return {5'h00, 3'(k - 1), p[k - 1]};
    if (k == 7) return {5'h01, 3'h0, BP_E1};
    return {5'h00, 3'h0, BP_IDLE};
  endfunction

  // issue one instruction alone and walk its exec stages
  task automatic run(input int u, input fbx_cls_t c);
    logic [4:0] t;
    logic [15:0] e;
    t = 5'($urandom);
    @(posedge clk_sys);
    iv[u] <= 1'b1;
    ic[u] <= c;
    it[u] <= t;
    @(posedge clk_sys);
    iv[u] <= 1'b0;
    for (int k = 1; k <= 11; k++) begin
      #1;
      e = want(u, c, k);
      cmp({5'h0, unitStatusUpd[u], unitBusy[u], auxStatusUpd, mulStatusUpd, addStatusUpd, readFirstLo[u], readFirstHi[u],
        readSecondLo[u], readSecondHi[u], writeLo[u], writeHi[u]}, e);
      if (e[1]) cmp(16'(writeTagLo[u]), 16'(t));
      if (e[0]) cmp(16'(writeTagHi[u]), 16'(t));
      if (c == CL_BRANCH) cmp({2'h0, branchExec, branchFetchGen, branchTargetExec, branchSlot, branchPhase}, bw(k));
      @(posedge clk_sys);
    end
  endtask

  initial begin
    void'($urandom(90099));
    for (int u = 0; u < FBX_UNITS; u++) ic[u] = CL_BRANCH;
    repeat (15) @(posedge clk_sys);
    #1;
    cmp(16'(unitReady), 16'h0);
    cmp(16'(branchPhase), 16'(BP_IDLE));
    @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // every class on a unit that may run it
    for (int i = 0; i < 10; i++) run(tu[i], tc[i]);
    // class sent to a unit that cannot run it
    @(posedge clk_sys);
    iv[0] <= 1'b1;
    ic[0] <= CL_DOUBLE_MULTIPLY;
    iv[1] <= 1'b1;
    ic[1] <= CL_BRANCH;
    @(posedge clk_sys);
    iv[0] <= 1'b0;
    iv[1] <= 1'b0;
    #1;
    cmp({14'h0, issueRefused[0], unitBusy[0]}, 16'h2);
    cmp({14'h0, issueRefused[1], branchExec}, 16'h2);
    // request held on a multiply unit: taken every fourth edge, refused between
    @(posedge clk_sys);
    iv[5] <= 1'b1;
    ic[5] <= CL_INT_MULTIPLY_32;
    @(posedge clk_sys);
    for (int k = 1; k <= 8; k++) begin
      #1;
      cmp({14'h0, unitBusy[5], issueRefused[5]}, {14'h0, k % 4 != 0, k > 1 && (k - 1) % 4 != 0});
      @(posedge clk_sys);
    end
    iv[5] <= 1'b0;
    repeat (12) @(posedge clk_sys);
    // random traffic on all units, branches left out
    repeat (400) begin
      @(posedge clk_sys);
      iv <= 6'($urandom);
      for (int u = 0; u < FBX_UNITS; u++) begin
        ic[u] <= fbx_cls_t'(4'(1 + $urandom % 8));
        it[u] <= 5'($urandom);
      end
    end
    @(posedge clk_sys);
    iv <= '0;
    repeat (12) @(posedge clk_sys);
    report_and_stop;
  end
endmodule

bind fbx_exec_timing fbx_exec_timing_sva i_fbx_exec_timing_sva (
  .clk_sys, .nrst, .issueValid, .issueCls, .unitReady, .issueRefused, .unitBusy, .readFirstLo, .readFirstHi,
  .readSecondLo, .readSecondHi, .writeLo, .writeHi, .auxStatusUpd, .mulStatusUpd, .addStatusUpd,
  .branchExec, .branchFetchGen, .branchTargetExec
);
